/* hdl/fgd_consts.svh */
`ifndef FGD_CONSTS_SVH
`define FGD_CONSTS_SVH

// Register offsets
`define FGD_OFS_CTRL 8'h00
`define FGD_OFS_STATUS 8'h04
`define FGD_OFS_INT_STAT 8'h08
`define FGD_OFS_INT_MASK 8'h0c

// Control register fields
`define FGD_CTRL_GCM_BIT 6
`define FGD_CTRL_FTX_BIT 7
`define FGD_CTRL_FRX_BIT 8
`define FGD_CTRL_DTX_BIT 9
`define FGD_CTRL_DRX_BIT 10
`define FGD_CTRL_RESET 32'h0000_0000

// Status register fields
`define FGD_STAT_CODE_LSB 0
`define FGD_STAT_CODE_MSB 7
`define FGD_STAT_CODE_VALID_BIT 8
`define FGD_STAT_GC_BUSY_BIT 9

// Interrupt bits
`define FGD_INT_WIDTH 5
`define FGD_INT_TXFL 0
`define FGD_INT_RXFL 1
`define FGD_INT_DTX 2
`define FGD_INT_DRX 3
`define FGD_INT_GCD 4
`define FGD_INT_RESET 5'h00

// General call codes
`define FGD_GC_CODE_RESET_ADDR 8'h06
`define FGD_GC_CODE_WRITE_ADDR 8'h04
`define FGD_GC_MODE_TRANSPARENT 1'b0
`define FGD_GC_MODE_DIRECT 1'b1

// Serial side enable: one tick every FGD_TICK_DIV mclk cycles
`define FGD_TICK_DIV 4'h4
`define FGD_TICK_MAX 4'h3

`endif

/* hdl/fgd_pkg.sv */
package fgd_pkg;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fgd_byte_t;

  typedef struct packed {
    logic reset_addr;
    logic write_addr;
  } fgd_gc_act_t;

  typedef enum logic [1:0] {
    FGD_GC_IDLE,
    FGD_GC_FIRST,
    FGD_GC_PASS,
    FGD_GC_DROP
  } fgd_gc_state_t;

endpackage

/* hdl/fgd_flush_hs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fgd_consts.svh"

module fgd_flush_hs (
  input wire logic mclk,
  input wire logic reset,
  input wire logic tick,
  input wire logic start,
  output logic busy,
  output logic path_clear,
  output logic done
);

  logic req;
  logic ack;
  logic pend;

  // System side request, four-phase against the serial side acknowledge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      req <= 1'b0;
    end else if (req && ack) begin
      req <= 1'b0;
    end else if (!req && !ack && (pend || start)) begin
      req <= 1'b1;
    end
  end

  // A start that arrives while a flush runs is kept, not lost
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pend <= 1'b0;
    end else if (start && (req || ack)) begin
      pend <= 1'b1;
    end else if (!req && !ack) begin
      pend <= 1'b0;
    end
  end

  // Serial side, advances only on the divided enable
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
    end else if (tick) begin
      ack <= req;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      path_clear <= 1'b0;
    end else begin
      path_clear <= tick && req && !ack;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      done <= 1'b0;
    end else begin
      done <= req && ack;
    end
  end

  assign busy = req || pend;

endmodule
`default_nettype wire

/* hdl/fgd_gcall.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fgd_consts.svh"

module fgd_gcall (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clear,
  input wire logic mode,
  input wire logic gc_addr_hit,
  input wire logic rx_stop,
  input wire fgd_pkg::fgd_byte_t rx_in,
  output fgd_pkg::fgd_byte_t fifo_push,
  output fgd_pkg::fgd_gc_act_t act,
  output fgd_pkg::fgd_byte_t code,
  output logic active
);

  fgd_pkg::fgd_gc_state_t state;
  logic hw_call;
  logic direct;

  assign hw_call = rx_in.data[0];
  assign direct = (mode == `FGD_GC_MODE_DIRECT) && !hw_call;
  assign active = (state != fgd_pkg::FGD_GC_IDLE);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= fgd_pkg::FGD_GC_IDLE;
    end else if (clear || rx_stop) begin
      state <= fgd_pkg::FGD_GC_IDLE;
    end else begin
      unique case (state)
        fgd_pkg::FGD_GC_IDLE: begin
          if (gc_addr_hit) begin
            state <= fgd_pkg::FGD_GC_FIRST;
          end
        end
        fgd_pkg::FGD_GC_FIRST: begin
          if (rx_in.valid) begin
            state <= direct ? fgd_pkg::FGD_GC_DROP : fgd_pkg::FGD_GC_PASS;
          end
        end
        fgd_pkg::FGD_GC_PASS: begin
        end
        fgd_pkg::FGD_GC_DROP: begin
        end
      endcase
    end
  end

  // Transparent calls, and hardware calls always, go to the FIFO
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fifo_push <= '0;
    end else begin
      fifo_push.data <= rx_in.data;
      fifo_push.valid <= rx_in.valid && !clear &&
        ((state == fgd_pkg::FGD_GC_PASS) ||
         ((state == fgd_pkg::FGD_GC_FIRST) && !direct));
    end
  end

  // Direct mode acts here and reports only the code word
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      act <= '0;
      code <= '0;
    end else begin
      act.reset_addr <= 1'b0;
      act.write_addr <= 1'b0;
      code.valid <= 1'b0;
      if (!clear && rx_in.valid && (state == fgd_pkg::FGD_GC_FIRST) &&
          direct) begin
        act.reset_addr <= (rx_in.data == `FGD_GC_CODE_RESET_ADDR);
        act.write_addr <= (rx_in.data == `FGD_GC_CODE_WRITE_ADDR);
        code.valid <= 1'b1;
        code.data <= rx_in.data;
      end
    end
  end

endmodule
`default_nettype wire

/* hdl/fgd_ctrl.sv */
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "fgd_consts.svh"

module fgd_ctrl (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic gc_addr_hit,
  input wire logic rx_stop,
  input wire fgd_pkg::fgd_byte_t rx_in,
  output fgd_pkg::fgd_byte_t rx_fifo_push,
  output fgd_pkg::fgd_gc_act_t gc_act,
  output logic tx_path_clear,
  output logic rx_path_clear,
  output logic serial_tick,
  input wire logic tx_fifo_space,
  input wire logic rx_fifo_data,
  input wire logic dma_tx_eot,
  input wire logic dma_rx_eot,
  output logic dma_tx_run,
  output logic dma_rx_run,
  output logic dma_tx_req,
  output logic dma_rx_req,
  output logic irq
);

  logic [3:0] div_cnt;
  logic gc_mode;
  logic dma_tx_en;
  logic dma_rx_en;
  logic [`FGD_INT_WIDTH-1:0] int_stat;
  logic [`FGD_INT_WIDTH-1:0] int_mask;
  logic [`FGD_INT_WIDTH-1:0] int_evt;
  logic [7:0] stat_code;
  logic stat_code_valid;
  logic wr_ctrl;
  logic wr_istat;
  logic wr_imask;
  logic tx_busy;
  logic rx_busy;
  logic tx_done;
  logic rx_done;
  logic gc_active;
  fgd_pkg::fgd_byte_t gc_code;
  logic [31:0] next_rdata;

  assign wr_ctrl = reg_wr && (reg_addr == `FGD_OFS_CTRL);
  assign wr_istat = reg_wr && (reg_addr == `FGD_OFS_INT_STAT);
  assign wr_imask = reg_wr && (reg_addr == `FGD_OFS_INT_MASK);

  // Divided enable for the serial side logic
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_cnt <= 4'h0;
      serial_tick <= 1'b0;
    end else if (div_cnt == `FGD_TICK_MAX) begin
      div_cnt <= 4'h0;
      serial_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 4'h1;
      serial_tick <= 1'b0;
    end
  end

  // Configuration is written only by software, never by a flush
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      gc_mode <= `FGD_GC_MODE_TRANSPARENT;
    end else if (wr_ctrl) begin
      gc_mode <= reg_wdata[`FGD_CTRL_GCM_BIT];
    end
  end

  // Transmit enable, end of transfer clears, a set in the same cycle wins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dma_tx_en <= 1'b0;
    end else if (wr_ctrl && reg_wdata[`FGD_CTRL_DTX_BIT]) begin
      dma_tx_en <= 1'b1;
    end else if (wr_ctrl || dma_tx_eot) begin
      dma_tx_en <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dma_rx_en <= 1'b0;
    end else if (wr_ctrl && reg_wdata[`FGD_CTRL_DRX_BIT]) begin
      dma_rx_en <= 1'b1;
    end else if (wr_ctrl || dma_rx_eot) begin
      dma_rx_en <= 1'b0;
    end
  end

  // DMA interfaces run only while enabled
  assign dma_tx_run = dma_tx_en;
  assign dma_rx_run = dma_rx_en;
  assign dma_tx_req = dma_tx_en && tx_fifo_space && !tx_busy;
  assign dma_rx_req = dma_rx_en && rx_fifo_data && !rx_busy;

  // Flush bits are set by writing one and cleared only by completion
  fgd_flush_hs u_tx_flush (
    .mclk(mclk),
    .reset(reset),
    .tick(serial_tick),
    .start(wr_ctrl && reg_wdata[`FGD_CTRL_FTX_BIT]),
    .busy(tx_busy),
    .path_clear(tx_path_clear),
    .done(tx_done)
  );

  fgd_flush_hs u_rx_flush (
    .mclk(mclk),
    .reset(reset),
    .tick(serial_tick),
    .start(wr_ctrl && reg_wdata[`FGD_CTRL_FRX_BIT]),
    .busy(rx_busy),
    .path_clear(rx_path_clear),
    .done(rx_done)
  );

  // Receive flush also returns the general call decoder to idle
  fgd_gcall u_gcall (
    .mclk(mclk),
    .reset(reset),
    .clear(rx_path_clear || rx_busy),
    .mode(gc_mode),
    .gc_addr_hit(gc_addr_hit),
    .rx_stop(rx_stop),
    .rx_in(rx_in),
    .fifo_push(rx_fifo_push),
    .act(gc_act),
    .code(gc_code),
    .active(gc_active)
  );

  // Status code word of a direct general call
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stat_code <= 8'h00;
      stat_code_valid <= 1'b0;
    end else if (gc_code.valid) begin
      stat_code <= gc_code.data;
      stat_code_valid <= 1'b1;
    end else if (reg_rd && (reg_addr == `FGD_OFS_STATUS)) begin
      stat_code_valid <= 1'b0;
    end
  end

  // Sticky events, write one to clear, a new event wins
  always_comb begin
    int_evt = '0;
    int_evt[`FGD_INT_TXFL] = tx_done;
    int_evt[`FGD_INT_RXFL] = rx_done;
    int_evt[`FGD_INT_DTX] = dma_tx_eot && dma_tx_en;
    int_evt[`FGD_INT_DRX] = dma_rx_eot && dma_rx_en;
    int_evt[`FGD_INT_GCD] = gc_code.valid;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      int_stat <= `FGD_INT_RESET;
    end else if (wr_istat) begin
      int_stat <= (int_stat & ~reg_wdata[`FGD_INT_WIDTH-1:0]) | int_evt;
    end else begin
      int_stat <= int_stat | int_evt;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      int_mask <= `FGD_INT_RESET;
    end else if (wr_imask) begin
      int_mask <= reg_wdata[`FGD_INT_WIDTH-1:0];
    end
  end

  assign irq = |(int_stat & int_mask);

  // Read data, one cycle after the strobe, zero elsewhere
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `FGD_OFS_CTRL: begin
          next_rdata[`FGD_CTRL_GCM_BIT] = gc_mode;
          next_rdata[`FGD_CTRL_FTX_BIT] = tx_busy;
          next_rdata[`FGD_CTRL_FRX_BIT] = rx_busy;
          next_rdata[`FGD_CTRL_DTX_BIT] = dma_tx_en;
          next_rdata[`FGD_CTRL_DRX_BIT] = dma_rx_en;
        end
        `FGD_OFS_STATUS: begin
          next_rdata[`FGD_STAT_CODE_MSB:`FGD_STAT_CODE_LSB] = stat_code;
          next_rdata[`FGD_STAT_CODE_VALID_BIT] = stat_code_valid;
          next_rdata[`FGD_STAT_GC_BUSY_BIT] = gc_active;
        end
        `FGD_OFS_INT_STAT: begin
          next_rdata[`FGD_INT_WIDTH-1:0] = int_stat;
        end
        `FGD_OFS_INT_MASK: begin
          next_rdata[`FGD_INT_WIDTH-1:0] = int_mask;
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

/* dv/fgd_ctrl_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module fgd_ctrl_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire fgd_pkg::fgd_byte_t rx_in,
  input wire fgd_pkg::fgd_byte_t rx_fifo_push,
  input wire fgd_pkg::fgd_gc_act_t gc_act,
  input wire logic gc_addr_hit,
  input wire logic tx_path_clear,
  input wire logic rx_path_clear,
  input wire logic serial_tick,
  input wire logic tx_fifo_space,
  input wire logic dma_tx_eot,
  input wire logic dma_tx_run,
  input wire logic dma_tx_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic cw;
  assign cw = reg_wr && reg_addr == 8'h00;
  tick_period_a: assert property (
    serial_tick |=> !serial_tick [*3] ##1 serial_tick)
    else $error("serial tick spacing");
  tx_flush_run_a: assert property (
    cw && reg_wdata[7] |-> ##[1:8] tx_path_clear)
    else $error("tx path not cleared");
  rx_flush_run_a: assert property (
    cw && reg_wdata[8] |-> ##[1:8] rx_path_clear)
    else $error("rx path not cleared");
  tx_req_gate_a: assert property (
    dma_tx_req |-> dma_tx_run && tx_fifo_space && !tx_path_clear)
    else $error("tx request while idle");
  tx_run_write_a: assert property (
    cw |=> dma_tx_run == $past(reg_wdata[9]))
    else $error("tx run not written");
  eot_stop_a: assert property (
    dma_tx_eot && !cw |=> !dma_tx_run)
    else $error("tx run kept after end");
  hw_call_a: assert property (
    gc_addr_hit ##1 (rx_in.valid && rx_in.data[0]) |=>
    rx_fifo_push.valid && rx_fifo_push.data == $past(rx_in.data))
    else $error("hardware call not pushed");
  direct_act_a: assert property (
    gc_act.reset_addr |-> $past(rx_in.data) == 8'h06 && !rx_fifo_push.valid)
    else $error("direct action wrong");
endmodule
bind fgd_ctrl fgd_ctrl_chk chk (.mclk, .reset, .reg_addr, .reg_wdata,
  .reg_wr, .rx_in, .rx_fifo_push, .gc_act, .gc_addr_hit, .tx_path_clear,
  .rx_path_clear, .serial_tick, .tx_fifo_space, .dma_tx_eot, .dma_tx_run,
  .dma_tx_req);
`default_nettype wire

/* dv/fgd_bus_node.sv */
`timescale 1ns/100ps
`default_nettype none
module fgd_bus_node (
  input wire logic mclk,
  output logic gc_addr_hit,
  output logic rx_stop,
  output fgd_pkg::fgd_byte_t rx_in
);
  initial begin
    gc_addr_hit = 1'b0;
    rx_stop = 1'b0;
    rx_in = {1'b0, 8'h5a};
  end
  // General call message: address match, n bytes each followed by gap+1 idle cycles, stop
  task automatic send(input logic [7:0] b, input int n, input int gap);
    @(posedge mclk);
    gc_addr_hit <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      gc_addr_hit <= 1'b0;
      rx_in <= {1'b1, b + i[7:0]};
      @(posedge mclk);
      rx_in <= {1'b0, ~(b + i[7:0])};
      repeat (gap) @(posedge mclk);
    end
    @(posedge mclk);
    rx_stop <= 1'b1;
    @(posedge mclk);
    rx_stop <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* dv/test_fgd_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module test_fgd_ctrl;
  logic mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
  logic gc_addr_hit, rx_stop, tx_path_clear, rx_path_clear, serial_tick;
  logic tx_fifo_space = 1'b0, rx_fifo_data = 1'b0, irq;
  logic [1:0] eot = 2'b00;
  logic dma_tx_run, dma_rx_run, dma_tx_req, dma_rx_req;
  logic [3:0] dma_st;
  fgd_pkg::fgd_byte_t rx_in, rx_fifo_push;
  fgd_pkg::fgd_gc_act_t gc_act;
  logic [7:0] gb [4] = '{8'h06, 8'h04, 8'h07, 8'h06};
  logic [31:0] gs [4] = '{32'h106, 32'h104, 32'h004, 32'h004};
  int err_total = 0, comparisons = 0, cyc = 0;
  int n_tx = 0, n_rx = 0, n_push = 0, n_act = 0;
  always #25 mclk = ~mclk;
  fgd_ctrl uut (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .gc_addr_hit, .rx_stop, .rx_in, .rx_fifo_push, .gc_act,
    .tx_path_clear, .rx_path_clear, .serial_tick, .tx_fifo_space,
    .rx_fifo_data, .dma_tx_eot(eot[0]), .dma_rx_eot(eot[1]), .dma_tx_run,
    .dma_rx_run, .dma_tx_req, .dma_rx_req, .irq);
  fgd_bus_node node (.mclk, .gc_addr_hit, .rx_stop, .rx_in);
  assign dma_st = {dma_rx_req, dma_tx_req, dma_rx_run, dma_tx_run};
  always @(posedge mclk) begin
    cyc++;
    n_tx += tx_path_clear;
    n_rx += rx_path_clear;
    n_push += rx_fifo_push.valid;
    n_act += gc_act.reset_addr + gc_act.write_addr;
    if (cyc == 4000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d compares %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    for (int a = 0; a <= 16; a += 4) begin
      rd(a[7:0]);
      chk(v, 32'h0);
    end
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10);
    chk(v, 32'h0);
    wr(8'h00, 32'h40);
    for (int k = 0; k < 2; k++) begin
      n_tx = 0;
      n_rx = 0;
      wr(8'h00, 32'h40 | (32'h80 << k));
      rd(8'h00);
      chk(v, 32'h40 | (32'h80 << k));
      for (int i = 0; i < 20 && v !== 32'h40; i++) rd(8'h00);
      chk(v, 32'h40);
      chk(n_tx * 16 + n_rx, k ? 1 : 16);
      rd(8'h08);
      chk(v, 32'h1 << k);
      chk(irq, 1'b0);
      wr(8'h0c, 32'h3);
      #1 chk(irq, 1'b1);
      wr(8'h08, 32'h1 << k);
      #1 chk(irq, 1'b0);
      wr(8'h0c, 32'h0);
    end
    // A second flush request during a flush is queued and run once more
    n_tx = 0;
    wr(8'h00, 32'h80);
    wr(8'h00, 32'h80);
    rd(8'h00);
    chk(v, 32'h80);
    for (int i = 0; i < 20 && v !== 32'h0; i++) rd(8'h00);
    chk(v, 32'h0);
    chk(n_tx, 2);
    wr(8'h08, 32'h1f);
    @(posedge mclk);
    tx_fifo_space <= 1'b1;
    rx_fifo_data <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      wr(8'h00, 32'h200 << j);
      #1 chk(dma_st, j ? 4'ha : 4'h5);
      @(posedge mclk);
      eot[j] <= 1'b1;
      @(posedge mclk);
      eot <= 2'b00;
      #1 chk(dma_st, 4'h0);
      rd(8'h08);
      chk(v, 32'h4 << j);
      wr(8'h08, 32'h1f);
    end
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, m < 3 ? 32'h40 : 32'h0);
      n_push = 0;
      n_act = 0;
      node.send(gb[m], 2, m);
      repeat (3) @(posedge mclk);
      chk(n_push * 16 + n_act, m < 2 ? 1 : 32);
      rd(8'h04);
      chk(v, gs[m]);
      @(posedge mclk);
      #1 chk(reg_rdata, 32'h0);
    end
    rd(8'h08);
    chk(v, 32'h10);
    tally_and_finish();
  end
endmodule
`default_nettype wire
